// File: src/acmof_core.sv
// execution of or/move/store/load-literal/no-op on the accumulator and file registers
`timescale 1ns/1ps
// Summary of operation
// - or-with-file computes accumulator OR addressed file register.
// - direction zero: or result goes to accumulator, file untouched.
// - direction one: or result written back to the addressed file register.
// - move-file copies file value unchanged; direction zero targets accumulator.
// - move-file direction one rewrites the same register with its own value.
// - move-file updates zero flag from the moved value.
// - store-accumulator copies accumulator to file register, flags untouched.
// - load-literal puts 8-bit immediate in accumulator, flags untouched.
module acmof_core
  import acmof_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  output logic [6:0] o_file_raddr,
  input wire logic [7:0] i_file_rdata,
  output logic o_file_wr_en,
  output logic [6:0] o_file_waddr,
  output logic [7:0] o_file_wdata,
  output logic [7:0] o_accum,
  output logic o_zero_flag,
  output logic o_pc_step,
  output logic o_unsupported
);

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  function automatic acmof_class_t acmof_decode(input logic [13:0] w);
    acmof_class_t c;
    c = ACMOF_CLS_OTHER;
    if (w[13:8] == ACMOF_OP_OR_FILE) begin
      c = ACMOF_CLS_OR_FILE;
    end else if (w[13:8] == ACMOF_OP_MOVE_FILE) begin
      c = ACMOF_CLS_MOVE_FILE;
    end else if (w[13:7] == ACMOF_OP_STORE_ACC) begin
      c = ACMOF_CLS_STORE_ACC;
    end else if (w[13:10] == ACMOF_OP_LOAD_LIT) begin
      c = ACMOF_CLS_LOAD_LIT;
    end else if (w[13:7] == ACMOF_OP_NOP_HI && w[4:0] == ACMOF_OP_NOP_LO) begin
      c = ACMOF_CLS_NOP;
    end
    return c;
  endfunction : acmof_decode

  wire acmof_class_t cls = i_instr_valid ? acmof_decode(i_instr) : ACMOF_CLS_OTHER;
  wire logic dir = i_instr[ACMOF_DIR_BIT];
  wire logic [6:0] faddr = i_instr[ACMOF_ADDR_LSB +: ACMOF_ADDR_W];
  wire logic [7:0] literal = i_instr[ACMOF_LIT_LSB +: ACMOF_DATA_W];
  wire logic known = (cls != ACMOF_CLS_OTHER);

  // --------------------------------------------------------------------
  // operand fetch with write forwarding
  // --------------------------------------------------------------------
  logic [7:0] accum_q;
  logic [7:0] accum_d;
  logic zero_q;
  logic zero_d;
  logic wr_en_q;
  logic [6:0] waddr_q;
  logic [7:0] wdata_q;

  // the file write lands one cycle late; forward it so back-to-back reads see it
  wire logic fwd_hit = wr_en_q && (waddr_q == faddr);
  wire logic [7:0] file_val = fwd_hit ? wdata_q : i_file_rdata;

  assign o_file_raddr = faddr;

  // --------------------------------------------------------------------
  // execute
  // --------------------------------------------------------------------
  logic [7:0] result;
  logic wr_accum;
  logic wr_file;
  logic wr_zero;

  acmof_exec_unit u_exec (
    .i_cls(cls),
    .i_dir(dir),
    .i_accum(accum_q),
    .i_file(file_val),
    .i_literal(literal),
    .o_result(result),
    .o_wr_accum(wr_accum),
    .o_wr_file(wr_file),
    .o_wr_zero(wr_zero)
  );

  assign accum_d = wr_accum ? result : accum_q;
  // only or-with-file and move-file touch the flag
  assign zero_d = wr_zero ? (result == 8'h00) : zero_q;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      accum_q <= ACMOF_ACCUM_RST;
      zero_q <= ACMOF_ZERO_RST;
    end else begin
      accum_q <= accum_d;
      zero_q <= zero_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_en_q <= 1'b0;
      waddr_q <= 7'h00;
      wdata_q <= 8'h00;
    end else begin
      wr_en_q <= wr_file;
      waddr_q <= faddr;
      wdata_q <= result;
    end
  end

  logic step_q;
  logic unsup_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      step_q <= 1'b0;
      unsup_q <= 1'b0;
    end else begin
      // each handled word retires in one cycle, no-op included
      step_q <= known;
      unsup_q <= i_instr_valid && !known;
    end
  end

  assign o_file_wr_en = wr_en_q;
  assign o_file_waddr = waddr_q;
  assign o_file_wdata = wdata_q;
  assign o_accum = accum_q;
  assign o_zero_flag = zero_q;
  assign o_pc_step = step_q;
  assign o_unsupported = unsup_q;

endmodule : acmof_core

// File: src/acmof_exec_unit.sv
// combinational result, destination and flag selection for one instruction class
`timescale 1ns/1ps
module acmof_exec_unit
  import acmof_pkg::*;
(
  input wire acmof_class_t i_cls,
  input wire logic i_dir,
  input wire logic [7:0] i_accum,
  input wire logic [7:0] i_file,
  input wire logic [7:0] i_literal,
  output logic [7:0] o_result,
  output logic o_wr_accum,
  output logic o_wr_file,
  output logic o_wr_zero
);

  // --------------------------------------------------------------------
  // result and destination
  // --------------------------------------------------------------------
  always_comb begin
    o_result = 8'h00;
    o_wr_accum = 1'b0;
    o_wr_file = 1'b0;
    o_wr_zero = 1'b0;
    case (i_cls)
      ACMOF_CLS_OR_FILE: begin
        o_result = i_accum | i_file;
        o_wr_accum = ~i_dir;
        o_wr_file = i_dir;
        o_wr_zero = 1'b1;
      end
      ACMOF_CLS_MOVE_FILE: begin
        o_result = i_file;
        o_wr_accum = ~i_dir;
        // rewrite of the same value keeps the register intact
        o_wr_file = i_dir;
        o_wr_zero = 1'b1;
      end
      ACMOF_CLS_STORE_ACC: begin
        o_result = i_accum;
        o_wr_file = 1'b1;
      end
      ACMOF_CLS_LOAD_LIT: begin
        o_result = i_literal;
        o_wr_accum = 1'b1;
      end
      default: begin
        o_result = 8'h00;
      end
    endcase
  end

endmodule : acmof_exec_unit

// File: src/acmof_pkg.sv
// package: opcode fields, decode patterns and reset values for the accumulator move/or block
package acmof_pkg;

  // --------------------------------------------------------------------
  // word layout
  // --------------------------------------------------------------------
  localparam int ACMOF_INSTR_W = 14;
  localparam int ACMOF_DATA_W = 8;
  localparam int ACMOF_ADDR_W = 7;
  localparam int ACMOF_DIR_BIT = 7;
  localparam int ACMOF_ADDR_LSB = 0;
  localparam int ACMOF_LIT_LSB = 0;

  // --------------------------------------------------------------------
  // opcode patterns
  // --------------------------------------------------------------------
  localparam logic [5:0] ACMOF_OP_OR_FILE = 6'h04;
  localparam logic [5:0] ACMOF_OP_MOVE_FILE = 6'h08;
  localparam logic [6:0] ACMOF_OP_STORE_ACC = 7'h01;
  localparam logic [3:0] ACMOF_OP_LOAD_LIT = 4'hc;
  localparam logic [6:0] ACMOF_OP_NOP_HI = 7'h00;
  localparam logic [4:0] ACMOF_OP_NOP_LO = 5'h00;

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] ACMOF_ACCUM_RST = 8'h00;
  localparam logic ACMOF_ZERO_RST = 1'b0;

  typedef enum logic [2:0] {
    ACMOF_CLS_OR_FILE,
    ACMOF_CLS_MOVE_FILE,
    ACMOF_CLS_STORE_ACC,
    ACMOF_CLS_LOAD_LIT,
    ACMOF_CLS_NOP,
    ACMOF_CLS_OTHER
  } acmof_class_t;

endpackage : acmof_pkg

// File: verification/acmof_core_asserts.sv
// checker: port assertions for the accumulator move/or core
`timescale 1ns/1ps
module acmof_core_asserts
  import acmof_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0] i_file_rdata,
  input wire logic o_file_wr_en,
  input wire logic [6:0] o_file_waddr,
  input wire logic [7:0] o_file_wdata,
  input wire logic [7:0] o_accum,
  input wire logic o_zero_flag,
  input wire logic o_pc_step
);
  wire logic or_w = i_instr_valid && i_instr[13:8] == ACMOF_OP_OR_FILE;
  wire logic mv_w = i_instr_valid && i_instr[13:8] == ACMOF_OP_MOVE_FILE;
  wire logic st_w = i_instr_valid && i_instr[13:7] == ACMOF_OP_STORE_ACC;
  wire logic ld_w = i_instr_valid && i_instr[13:10] == ACMOF_OP_LOAD_LIT;
  wire logic np_w = i_instr_valid && i_instr[13:7] == ACMOF_OP_NOP_HI
    && i_instr[4:0] == ACMOF_OP_NOP_LO;
  // a pending write to the same address wins over the file read port
  wire logic [7:0] fv_w = (o_file_wr_en && o_file_waddr == i_instr[6:0]) ? o_file_wdata
    : i_file_rdata;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  or_value_a: assert property (or_w |=>
    ($past(i_instr[7]) ? o_file_wdata : o_accum) == ($past(o_accum) | $past(fv_w)))
    else $error("or result wrong");
  or_to_accum_a: assert property (or_w && !i_instr[7] |=>
    !o_file_wr_en && o_pc_step) else $error("or to accumulator wrote a file");
  or_to_file_a: assert property (or_w && i_instr[7] |=>
    o_file_wr_en && $stable(o_accum) && o_file_waddr == $past(i_instr[6:0]))
    else $error("or to file bad write");
  or_zero_a: assert property (or_w |=> o_zero_flag ==
    ($past(i_instr[7]) ? o_file_wdata == 8'h00 : o_accum == 8'h00)) else $error("or zero flag");
  move_value_a: assert property (mv_w |=>
    ($past(i_instr[7]) ? o_file_wdata : o_accum) == $past(fv_w)) else $error("move result wrong");
  move_zero_a: assert property (mv_w |=> o_zero_flag ==
    ($past(i_instr[7]) ? o_file_wdata == 8'h00 : o_accum == 8'h00)) else $error("move zero flag");
  move_self_a: assert property (mv_w && i_instr[7] |=>
    o_file_wr_en && $stable(o_accum) && o_file_waddr == $past(i_instr[6:0]))
    else $error("move to file bad");
  store_acc_a: assert property (st_w |=>
    o_file_wr_en && o_file_wdata == $past(o_accum) && $stable(o_zero_flag))
    else $error("store accumulator bad");
  load_lit_a: assert property (ld_w |=>
    o_accum == $past(i_instr[7:0]) && $stable(o_zero_flag)) else $error("load literal bad");
  nop_idle_a: assert property (np_w |=>
    o_pc_step && !o_file_wr_en && $stable(o_accum) && $stable(o_zero_flag))
    else $error("no-op changed state");
endmodule : acmof_core_asserts
bind acmof_core acmof_core_asserts chk_u (.*);

// File: verification/testbench.sv
// bench: model-checked random and directed stimulus for the core
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys = 0, i_sys_rst = 1, i_instr_valid = 0;
  logic [13:0] i_instr = 0;
  logic o_file_wr_en, o_zero_flag, o_pc_step, o_unsupported, mz;
  logic [6:0] o_file_raddr, o_file_waddr;
  logic [7:0] o_file_wdata, o_accum, ma, mem [128], m [128];
  logic [31:0] seed = 32'h9bbae9e0;
  logic [13:0] base [6] = '{14'h0400, 14'h0800, 14'h0080, 14'h3000, 14'h0000, 14'h3400};
  logic [13:0] mask [6] = '{14'h008f, 14'h008f, 14'h000f, 14'h03ff, 14'h0060, 14'h00ff};
  int n_errors = 0, num_checks = 0, k;
  // bench file is written one cycle late, so back-to-back reads lean on forwarding
  wire logic [7:0] i_file_rdata = mem[o_file_raddr];
  acmof_core dut_u (.i_clk_sys, .i_sys_rst, .i_instr_valid, .i_instr, .o_file_raddr,
    .i_file_rdata, .o_file_wr_en, .o_file_waddr, .o_file_wdata, .o_accum, .o_zero_flag,
    .o_pc_step, .o_unsupported);
  initial forever #2.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (o_file_wr_en) mem[o_file_waddr] <= o_file_wdata;
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic run(input logic [13:0] w);
    logic [7:0] r = 8'h00, f = m[w[6:0]];
    logic wr = 1'b0, st = 1'b1, un = 1'b0;
    @(negedge i_clk_sys);
    i_instr_valid = 1'b1;
    i_instr = w;
    #1 chk({1'b0, o_file_raddr}, {1'b0, w[6:0]});
    casez (w)
      14'b00_0100_????_????, 14'b00_1000_????_????: begin
        r = w[11] ? f : ma | f;
        mz = r == 8'h00;
        if (w[7]) wr = 1'b1;
        else ma = r;
      end
      14'b00_0000_1???_????: begin
        r = ma;
        wr = 1'b1;
      end
      14'b11_00??_????_????: ma = w[7:0];
      14'b00_0000_0??0_0000: ;
      default: {st, un} = 2'b01;
    endcase
    if (wr) m[w[6:0]] = r;
    @(posedge i_clk_sys);
    #1;
    chk(o_accum, ma);
    chk({7'h00, o_zero_flag}, {7'h00, mz});
    chk({7'h00, o_file_wr_en}, {7'h00, wr});
    chk({7'h00, o_pc_step}, {7'h00, st});
    chk({7'h00, o_unsupported}, {7'h00, un});
    if (wr) chk({1'b0, o_file_waddr}, {1'b0, w[6:0]});
    if (wr) chk(o_file_wdata, r);
  endtask : run
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = xs();
      m[i] = mem[i];
    end
    {ma, mz} = 9'h000;
    repeat (10) @(posedge i_clk_sys);
    @(negedge i_clk_sys) i_sys_rst = 0;
    // zero result path, then back-to-back same-address accesses
    run(14'h3000);
    run(14'h0085);
    run(14'h0485);
    run(14'h0885);
    run(14'h0805);
    run(14'h0060);
    run(14'h3400);
    for (int n = 0; n < 400; n++) begin
      // mask must belong to the chosen class, or most words fall out of it
      k = xs() % 6;
      run(base[k] | (14'({xs(), xs()}) & mask[k]));
      if (n == 199) begin
        // mid-run reset: accumulator and flag go back, file contents are kept
        @(negedge i_clk_sys);
        i_sys_rst = 1'b1;
        i_instr_valid = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        {ma, mz} = 9'h000;
        run(14'h0081);
      end
    end
    @(negedge i_clk_sys) i_instr_valid = 0;
    conclude();
  end
endmodule : testbench
